// file: verilog/mpg_regs.svh
// register offsets, reset values, bit masks and timing counts of the gpio block
// assumes inclusion by bare name from the design files, after the package
`ifndef MPG_REGS_SVH
`define MPG_REGS_SVH

// ==========================================================================
// register offsets in the logical device configuration space
`define MPG_OFS_ENABLE 8'h30
`define MPG_OFS_DIR7 8'he0
`define MPG_OFS_DATA7 8'he1
`define MPG_OFS_INV7 8'he2
`define MPG_OFS_EVT7 8'he3
`define MPG_OFS_DIR8 8'he4
`define MPG_OFS_DATA8 8'he5
`define MPG_OFS_INV8 8'he6
`define MPG_OFS_EVT8 8'he7
`define MPG_OFS_FSEL7 8'hec
`define MPG_OFS_FSEL8 8'hed
`define MPG_OFS_DIR6 8'hf4
`define MPG_OFS_DATA6 8'hf5
`define MPG_OFS_INV6 8'hf6
`define MPG_OFS_EVT6 8'hf7
`define MPG_OFS_FSEL6 8'hf8

// ==========================================================================
// reset values and implemented bits
`define MPG_RST_ENABLE 3'h0
`define MPG_RST_DIR6 8'hff
`define MPG_RST_DIR7 8'h7f
`define MPG_RST_DIR8 8'hff
`define MPG_RST_ZERO 8'h00
`define MPG_MASK6 8'hff
`define MPG_MASK7 8'h7f
`define MPG_MASK8 8'hff
`define MPG_ALT_BITS7 4
`define MPG_ALT_BITS68 8

// ==========================================================================
// cycles after reset before edge detection is trusted (sync chain fill)
`define MPG_PRIME_CYCLES 2'h3

`endif

// file: verilog/mpg_pkg.sv
// state type of the gpio block top module
// assumes nothing of its surroundings
`default_nettype none

package mpg_pkg;

   // ========================================================================
   // state of the top module; index 0 = port six, 1 = port seven, 2 = port eight
   typedef struct packed {
      logic [2:0] enable;
      logic [2:0][7:0] dir;
      logic [2:0][7:0] data;
      logic [2:0][7:0] inv;
      logic [2:0][7:0] evt;
      logic [2:0][7:0] fsel;
      logic [2:0][7:0] prev;
      logic [2:0][7:0] pin_out;
      logic [2:0][7:0] pin_oe;
      logic [1:0] prime;
      logic [7:0] rdata;
      logic rd_valid;
   } mpg_state_t;

endpackage : mpg_pkg

`default_nettype wire

// file: verilog/mpg_sync.sv
// two flip-flop synchroniser for pin inputs
// assumes the inputs are asynchronous to clk
`timescale 1ns/1ps
`default_nettype none

module mpg_sync #(
   parameter int W = 8
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);

   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } mpg_sync_t;

   mpg_sync_t s;
   mpg_sync_t next_s;

   // ========================================================================
   // the first stage feeds only the second stage
   always_comb begin
      next_s.meta = din;
      next_s.stable = s.meta;
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign dout = s.stable;

endmodule : mpg_sync

`default_nettype wire

// file: verilog/mpg_altmux.sv
// per-pin choice between plain port value and an alternate function signal
// assumes src is indexed by pin number modulo four, all signals on clk
`timescale 1ns/1ps
`default_nettype none

module mpg_altmux #(
   parameter int ALT_BITS = 8
) (
   input wire logic [7:0] fsel,
   input wire logic [7:0] plain,
   input wire logic [3:0] src,
   output logic [7:0] pin
);

   // ========================================================================
   // pins at ALT_BITS and above never take an alternate signal
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (i < ALT_BITS && fsel[i]) begin
            pin[i] = src[i % 4];
         end else begin
            pin[i] = plain[i];
         end
      end
   end

endmodule : mpg_altmux

`default_nettype wire

// file: verilog/mpg_gpio.sv
// three general purpose ports (8, 7 and 8 pins) with configuration registers
// assumes cfg_wr/cfg_rd are already qualified for this logical device and come
// from clk logic; port resets and standby reset are synchronous to clk
`include "mpg_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module mpg_gpio (
   input wire logic clk,
   input wire logic nrst,
   input wire logic standby_resume_reset_n,
   input wire logic port_six_reset,
   input wire logic port_seven_reset,
   input wire logic port_eight_reset,
   input wire logic [7:0] cfg_addr,
   input wire logic cfg_wr,
   input wire logic cfg_rd,
   input wire logic [7:0] cfg_wdata,
   output logic [7:0] cfg_rdata,
   output logic cfg_rd_valid,
   input wire logic watchdog_timeout_out,
   input wire logic management_interrupt_out,
   input wire logic beeper_out,
   input wire logic green_led_out,
   input wire logic yellow_led_out,
   input wire logic status_led_out,
   input wire logic [7:0] port_six_in,
   output logic [7:0] port_six_out,
   output logic [7:0] port_six_oe,
   input wire logic [6:0] port_seven_in,
   output logic [6:0] port_seven_out,
   output logic [6:0] port_seven_oe,
   input wire logic [7:0] port_eight_in,
   output logic [7:0] port_eight_out,
   output logic [7:0] port_eight_oe
);

   // ========================================================================
   // constants
   localparam logic [2:0][7:0] MASK = {`MPG_MASK8, `MPG_MASK7, `MPG_MASK6};
   localparam logic [2:0][7:0] RST_DIR = {`MPG_RST_DIR8, `MPG_RST_DIR7, `MPG_RST_DIR6};
   localparam mpg_pkg::mpg_state_t RST_STATE = '{
      enable: `MPG_RST_ENABLE,
      dir: RST_DIR,
      default: '0
   };

   mpg_pkg::mpg_state_t s;
   mpg_pkg::mpg_state_t next_s;
   logic [22:0] sync_q;
   logic [2:0][7:0] sync;
   logic [2:0][7:0] alt_pin;
   logic [2:0] port_rst;

   // ========================================================================
   // pin synchronisers
   mpg_sync #(
      .W(23)
   ) u_sync (
      .clk(clk),
      .nrst(nrst),
      .din({port_eight_in, port_seven_in, port_six_in}),
      .dout(sync_q)
   );

   assign sync[0] = sync_q[7:0];
   assign sync[1] = {1'b0, sync_q[14:8]}; // bit 7 of port seven never exists
   assign sync[2] = sync_q[22:15];
   assign port_rst = {port_eight_reset, port_seven_reset, port_six_reset};

   // ========================================================================
   // alternate function routing, one mux per port
   mpg_altmux #(
      .ALT_BITS(`MPG_ALT_BITS68)
   ) u_alt6 (
      .fsel(s.fsel[0]),
      .plain(s.data[0] ^ s.inv[0]),
      .src({status_led_out, beeper_out, management_interrupt_out, watchdog_timeout_out}),
      .pin(alt_pin[0])
   );

   mpg_altmux #(
      .ALT_BITS(`MPG_ALT_BITS7)
   ) u_alt7 (
      .fsel(s.fsel[1]),
      .plain(s.data[1] ^ s.inv[1]),
      .src({watchdog_timeout_out, management_interrupt_out, beeper_out, green_led_out}),
      .pin(alt_pin[1])
   );

   mpg_altmux #(
      .ALT_BITS(`MPG_ALT_BITS68)
   ) u_alt8 (
      .fsel(s.fsel[2]),
      .plain(s.data[2] ^ s.inv[2]),
      .src({yellow_led_out, beeper_out, management_interrupt_out, watchdog_timeout_out}),
      .pin(alt_pin[2])
   );

   // ========================================================================
   // data register view: stored bits for outputs, pin level xor inversion for inputs
   function automatic logic [7:0] data_view(
      input logic [7:0] d,
      input logic [7:0] dir,
      input logic [7:0] inv,
      input logic [7:0] pin,
      input logic [7:0] mask
   );
      data_view = ((d & ~dir) | ((pin ^ inv) & dir)) & mask;
   endfunction : data_view

   // writes land only in output bits; input bits keep nothing new
   function automatic logic [7:0] data_write(
      input logic [7:0] d,
      input logic [7:0] dir,
      input logic [7:0] w,
      input logic [7:0] mask
   );
      data_write = ((w & ~dir) | (d & dir)) & mask;
   endfunction : data_write

   // ========================================================================
   // next state
   always_comb begin
      logic [2:0][7:0] evt_clr;
      logic [2:0][7:0] evt_set;
      evt_clr = '0;
      evt_set = '0;
      next_s = s;
      next_s.rd_valid = 1'b0;

      // edge detect on synchronised pins; held off until the chain is filled
      for (int p = 0; p < 3; p++) begin
         next_s.prev[p] = sync[p];
         if (s.enable[p] && s.prime == `MPG_PRIME_CYCLES) begin
            evt_set[p] = (sync[p] ^ s.prev[p]) & MASK[p];
         end
      end
      if (s.prime != `MPG_PRIME_CYCLES) begin
         next_s.prime = s.prime + 2'h1;
      end

      // register read; the answer is registered and a read of an event register clears it
      if (cfg_rd) begin
         next_s.rd_valid = 1'b1;
         if (cfg_addr == `MPG_OFS_ENABLE) begin
            next_s.rdata = {5'h00, s.enable};
         end else if (cfg_addr == `MPG_OFS_DIR6) begin
            next_s.rdata = s.dir[0];
         end else if (cfg_addr == `MPG_OFS_DATA6) begin
            next_s.rdata = data_view(s.data[0], s.dir[0], s.inv[0], sync[0], MASK[0]);
         end else if (cfg_addr == `MPG_OFS_INV6) begin
            next_s.rdata = s.inv[0];
         end else if (cfg_addr == `MPG_OFS_EVT6) begin
            next_s.rdata = s.evt[0];
            evt_clr[0] = 8'hff;
         end else if (cfg_addr == `MPG_OFS_FSEL6) begin
            next_s.rdata = s.fsel[0];
         end else if (cfg_addr == `MPG_OFS_DIR7) begin
            next_s.rdata = s.dir[1];
         end else if (cfg_addr == `MPG_OFS_DATA7) begin
            next_s.rdata = data_view(s.data[1], s.dir[1], s.inv[1], sync[1], MASK[1]);
         end else if (cfg_addr == `MPG_OFS_INV7) begin
            next_s.rdata = s.inv[1];
         end else if (cfg_addr == `MPG_OFS_EVT7) begin
            next_s.rdata = s.evt[1];
            evt_clr[1] = 8'hff;
         end else if (cfg_addr == `MPG_OFS_FSEL7) begin
            next_s.rdata = s.fsel[1];
         end else if (cfg_addr == `MPG_OFS_DIR8) begin
            next_s.rdata = s.dir[2];
         end else if (cfg_addr == `MPG_OFS_DATA8) begin
            next_s.rdata = data_view(s.data[2], s.dir[2], s.inv[2], sync[2], MASK[2]);
         end else if (cfg_addr == `MPG_OFS_INV8) begin
            next_s.rdata = s.inv[2];
         end else if (cfg_addr == `MPG_OFS_EVT8) begin
            next_s.rdata = s.evt[2];
            evt_clr[2] = 8'hff;
         end else if (cfg_addr == `MPG_OFS_FSEL8) begin
            next_s.rdata = s.fsel[2];
         end else begin
            next_s.rdata = 8'h00; // unmapped offsets read as zero
         end
      end

      // an edge in the clearing cycle survives: set wins over clear
      for (int p = 0; p < 3; p++) begin
         next_s.evt[p] = (s.evt[p] & ~evt_clr[p]) | evt_set[p];
      end

      // register write; event registers are read-only and ignore writes
      if (cfg_wr) begin
         if (cfg_addr == `MPG_OFS_ENABLE) begin
            next_s.enable = cfg_wdata[2:0];
         end else if (cfg_addr == `MPG_OFS_DIR6) begin
            next_s.dir[0] = cfg_wdata & MASK[0];
         end else if (cfg_addr == `MPG_OFS_DATA6) begin
            next_s.data[0] = data_write(s.data[0], s.dir[0], cfg_wdata, MASK[0]);
         end else if (cfg_addr == `MPG_OFS_INV6) begin
            next_s.inv[0] = cfg_wdata & MASK[0];
         end else if (cfg_addr == `MPG_OFS_FSEL6) begin
            next_s.fsel[0] = cfg_wdata & MASK[0];
         end else if (cfg_addr == `MPG_OFS_DIR7) begin
            next_s.dir[1] = cfg_wdata & MASK[1];
         end else if (cfg_addr == `MPG_OFS_DATA7) begin
            next_s.data[1] = data_write(s.data[1], s.dir[1], cfg_wdata, MASK[1]);
         end else if (cfg_addr == `MPG_OFS_INV7) begin
            next_s.inv[1] = cfg_wdata & MASK[1];
         end else if (cfg_addr == `MPG_OFS_FSEL7) begin
            next_s.fsel[1] = cfg_wdata & MASK[1];
         end else if (cfg_addr == `MPG_OFS_DIR8) begin
            next_s.dir[2] = cfg_wdata & MASK[2];
         end else if (cfg_addr == `MPG_OFS_DATA8) begin
            next_s.data[2] = data_write(s.data[2], s.dir[2], cfg_wdata, MASK[2]);
         end else if (cfg_addr == `MPG_OFS_INV8) begin
            next_s.inv[2] = cfg_wdata & MASK[2];
         end else if (cfg_addr == `MPG_OFS_FSEL8) begin
            next_s.fsel[2] = cfg_wdata & MASK[2];
         end
      end

      // pins are registered from the current state, one cycle behind it;
      // an alternate signal only reaches the wire if software made it an output
      for (int p = 0; p < 3; p++) begin
         next_s.pin_out[p] = alt_pin[p] & MASK[p];
         next_s.pin_oe[p] = ~s.dir[p] & MASK[p] & {8{s.enable[p]}};
      end

      // per-port resets, then the standby reset of the enable register
      for (int p = 0; p < 3; p++) begin
         if (port_rst[p]) begin
            next_s.dir[p] = RST_DIR[p];
            next_s.data[p] = `MPG_RST_ZERO;
            next_s.inv[p] = `MPG_RST_ZERO;
            next_s.evt[p] = `MPG_RST_ZERO;
            next_s.fsel[p] = `MPG_RST_ZERO;
            next_s.pin_oe[p] = `MPG_RST_ZERO;
         end
      end
      if (!standby_resume_reset_n) begin
         next_s.enable = `MPG_RST_ENABLE;
      end
   end

   // ========================================================================
   // state register
   always_ff @(posedge clk) begin
      if (!nrst) begin
         s <= RST_STATE;
      end else begin
         s <= next_s;
      end
   end

   // ========================================================================
   // outputs straight from the state register
   assign cfg_rdata = s.rdata;
   assign cfg_rd_valid = s.rd_valid;
   assign port_six_out = s.pin_out[0];
   assign port_six_oe = s.pin_oe[0];
   assign port_seven_out = s.pin_out[1][6:0];
   assign port_seven_oe = s.pin_oe[1][6:0];
   assign port_eight_out = s.pin_out[2];
   assign port_eight_oe = s.pin_oe[2];

   // ========================================================================
   // assertions
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   sequence s_plain6;
      s.fsel[0] == 8'h00;
   endsequence

   sequence s_edge6;
      s.enable[0] && s.prime == 2'h3 && (sync[0][3] != s.prev[0][3]) && !port_six_reset;
   endsequence

   sequence s_quiet8;
      !port_eight_reset && (sync[2] == s.prev[2] || !s.enable[2]);
   endsequence

   a_enable_reset: assert property (!standby_resume_reset_n |=> s.enable == 3'h0)
      else $error("enable register not cleared by standby reset");

   a_enable_gates: assert property (!s.enable[1] |=> port_seven_oe == 7'h00)
      else $error("inactive port drives its pins");

   a_dir_reset: assert property (port_eight_reset |=> s.dir[2] == 8'hff && s.data[2] == 8'h00)
      else $error("port eight reset values wrong");

   a_oe_from_dir: assert property (s.enable[0] && !port_six_reset |=> port_six_oe == ~$past(s.dir[0]))
      else $error("output enable does not follow direction");

   a_resv_bit7: assert property (cfg_wr && cfg_addr == 8'he0 && !port_seven_reset
      |=> s.dir[1] == {1'b0, $past(cfg_wdata[6:0])})
      else $error("port seven bit 7 stored");

   a_plain_drive: assert property (s_plain6 |=> port_six_out == ($past(s.data[0]) ^ $past(s.inv[0])))
      else $error("port six pin value not data xor inversion");

   a_input_ignore: assert property (cfg_wr && cfg_addr == 8'he5 && s.dir[2] == 8'hff && !port_eight_reset
      |=> s.data[2] == $past(s.data[2]))
      else $error("write to input bits was stored");

   a_input_read: assert property (cfg_rd && cfg_addr == 8'hf5 && s.dir[0] == 8'hff
      |=> cfg_rd_valid && cfg_rdata == ($past(sync[0]) ^ $past(s.inv[0])))
      else $error("input read is not pin xor inversion");

   a_event_set: assert property (s_edge6 |=> s.evt[0][3])
      else $error("edge did not set event bit");

   a_read_clear: assert property ((cfg_rd && cfg_addr == 8'he7) and s_quiet8
      |=> cfg_rdata == $past(s.evt[2]) && s.evt[2] == 8'h00)
      else $error("event read did not return and clear");

   a_port7_map: assert property (s.enable[1] && s.prime == 2'h3 && sync[1][6] != s.prev[1][6]
      && !port_seven_reset |=> s.evt[1][6])
      else $error("port seven event bit mapping wrong");

   a_port7_alt: assert property (s.fsel[1][0] |=> port_seven_out[0] == $past(green_led_out))
      else $error("green led not routed");

   a_port8_alt: assert property (s.fsel[2][7] |=> port_eight_out[7] == $past(yellow_led_out))
      else $error("yellow led not routed");

   a_port6_alt: assert property (s.fsel[0][7] && s.fsel[0][4]
      |=> port_six_out[7] == $past(status_led_out) && port_six_out[4] == $past(watchdog_timeout_out))
      else $error("port six alternate routing wrong");

   a_no_edge_hold: assert property (!cfg_rd && !s.evt[0][0] && sync[0][0] == s.prev[0][0]
      |=> !s.evt[0][0])
      else $error("event set without an edge");

endmodule : mpg_gpio

`default_nettype wire

// file: tb/mpg_board.sv
// board-side model of the pins of one gpio port
// assumes out/oe come from the gpio block and lvl from the bench
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// pin resolution
module mpg_board #(
   parameter int W = 8
) (
   input wire logic [W-1:0] out,
   input wire logic [W-1:0] oe,
   input wire logic [W-1:0] lvl,
   output logic [W-1:0] pin
);
   // the board drives through a series resistor, so an enabled block driver wins
   always_comb begin
      for (int i = 0; i < W; i++) begin
         pin[i] = oe[i] ? out[i] : lvl[i];
      end
   end
endmodule : mpg_board

`default_nettype wire

// file: tb/mpg_gpio_tb.sv
// self-checking bench for the three-port gpio block
// assumes the design files and the board model are compiled before it
`include "mpg_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module mpg_gpio_tb;
   // ========================================================================
   // stimulus and observed signals
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic sby_n = 1'b1;
   logic rst6 = 1'b0, rst7 = 1'b0, rst8 = 1'b0;
   logic [7:0] cfg_addr = 8'h00, cfg_wdata = 8'h00, cfg_rdata;
   logic cfg_wr = 1'b0, cfg_rd = 1'b0, cfg_rd_valid;
   logic [5:0] alt = 6'h00; // status, yellow, green, beeper, interrupt, watchdog
   logic [7:0] drv6 = 8'h00, drv8 = 8'h00, out6, oe6, in6, out8, oe8, in8;
   logic [6:0] drv7 = 7'h00, out7, oe7, in7;
   int failures = 0;
   int checked = 0;
   localparam logic [7:0] RST_OFS [17] = '{`MPG_OFS_ENABLE, `MPG_OFS_DIR7, `MPG_OFS_DATA7,
      `MPG_OFS_INV7, `MPG_OFS_EVT7, `MPG_OFS_DIR8, `MPG_OFS_DATA8, `MPG_OFS_INV8,
      `MPG_OFS_EVT8, `MPG_OFS_FSEL7, `MPG_OFS_FSEL8, `MPG_OFS_DIR6, `MPG_OFS_DATA6,
      `MPG_OFS_INV6, `MPG_OFS_EVT6, `MPG_OFS_FSEL6, 8'h31};
   localparam logic [7:0] RST_VAL [17] = '{8'h00, 8'h7f, 8'h00, 8'h00, 8'h00, 8'hff,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

   always #4 clk = ~clk;

   // ========================================================================
   // block and board
   mpg_gpio i_mpg_gpio (.clk(clk), .nrst(nrst), .standby_resume_reset_n(sby_n),
      .port_six_reset(rst6), .port_seven_reset(rst7), .port_eight_reset(rst8),
      .cfg_addr(cfg_addr), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_wdata(cfg_wdata),
      .cfg_rdata(cfg_rdata), .cfg_rd_valid(cfg_rd_valid), .watchdog_timeout_out(alt[0]),
      .management_interrupt_out(alt[1]), .beeper_out(alt[2]), .green_led_out(alt[3]),
      .yellow_led_out(alt[4]), .status_led_out(alt[5]), .port_six_in(in6),
      .port_six_out(out6), .port_six_oe(oe6), .port_seven_in(in7), .port_seven_out(out7),
      .port_seven_oe(oe7), .port_eight_in(in8), .port_eight_out(out8), .port_eight_oe(oe8));
   mpg_board #(.W(8)) i_mpg_board_six (.out(out6), .oe(oe6), .lvl(drv6), .pin(in6));
   mpg_board #(.W(7)) i_mpg_board_seven (.out(out7), .oe(oe7), .lvl(drv7), .pin(in7));
   mpg_board #(.W(8)) i_mpg_board_eight (.out(out8), .oe(oe8), .lvl(drv8), .pin(in8));

   // ========================================================================
   // shared tasks
   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %0t %s: got %h want %h", $time, msg, seen, exp);
      end
   endtask : check

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      cfg_addr <= a;
      cfg_wdata <= d;
      cfg_wr <= 1'b1;
      @(posedge clk);
      cfg_wr <= 1'b0;
   endtask : wr_reg

   // the answer comes one cycle after the strobe and valid stands only then,
   // so it is taken just after the edge that samples the strobe
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk);
      cfg_addr <= a;
      cfg_rd <= 1'b1;
      @(posedge clk);
      cfg_rd <= 1'b0;
      #1;
      check({7'h00, cfg_rd_valid}, 8'h01, "read valid");
      v = cfg_rdata;
   endtask : rd_reg

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string msg);
      logic [7:0] v;
      rd_reg(a, v);
      check(v, exp, msg);
   endtask : rd_chk

   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : settle

   // ========================================================================
   // scenarios
   task automatic t_reset;
      check(oe6 | oe8 | {1'b0, oe7}, 8'h00, "oe after reset");
      for (int i = 0; i < 17; i++) begin
         rd_chk(RST_OFS[i], RST_VAL[i], "reset value");
      end
      wr_reg(`MPG_OFS_ENABLE, 8'hff);
      rd_chk(`MPG_OFS_ENABLE, 8'h07, "enable bits");
   endtask : t_reset

   // low nibble of port six out, high nibble in, then inverted
   task automatic t_data;
      @(posedge clk);
      drv6 <= 8'ha0;
      wr_reg(`MPG_OFS_DIR6, 8'hf0);
      wr_reg(`MPG_OFS_DATA6, 8'hff);
      settle(4);
      check(oe6, 8'h0f, "port six oe");
      check(out6, 8'h0f, "port six out");
      rd_chk(`MPG_OFS_DATA6, 8'haf, "mixed data read");
      wr_reg(`MPG_OFS_INV6, 8'hff);
      settle(3);
      check(out6, 8'hf0, "inverted out");
      rd_chk(`MPG_OFS_DATA6, 8'h5f, "inverted read");
      wr_reg(`MPG_OFS_INV6, 8'h00);
      wr_reg(`MPG_OFS_DIR6, 8'h00);
      rd_chk(`MPG_OFS_DATA6, 8'h0f, "input writes dropped");
      wr_reg(`MPG_OFS_DIR7, 8'hff);
      rd_chk(`MPG_OFS_DIR7, 8'h7f, "port seven bit 7");
   endtask : t_data

   task automatic t_event;
      // high nibble from the board, low nibble from the block driving its own pins
      rd_chk(`MPG_OFS_EVT6, 8'haf, "port six edges");
      @(posedge clk);
      drv8 <= 8'h84;
      settle(6);
      rd_chk(`MPG_OFS_EVT8, 8'h84, "port eight edges");
      rd_chk(`MPG_OFS_EVT8, 8'h00, "cleared by read");
      wr_reg(`MPG_OFS_EVT8, 8'hff);
      rd_chk(`MPG_OFS_EVT8, 8'h00, "event write ignored");
      wr_reg(`MPG_OFS_DATA8, 8'hff);
      rd_chk(`MPG_OFS_DATA8, 8'h84, "input read ignores write");
      @(posedge clk);
      drv7 <= 7'h40;
      drv8 <= 8'h00;
      settle(6);
      rd_chk(`MPG_OFS_EVT7, 8'h40, "port seven pin 6");
      wr_reg(`MPG_OFS_DIR8, 8'h00);
      @(posedge clk);
      rst8 <= 1'b1;
      @(posedge clk);
      rst8 <= 1'b0;
      rd_chk(`MPG_OFS_EVT8, 8'h00, "port reset clears events");
      rd_chk(`MPG_OFS_DIR8, 8'hff, "port reset direction");
   endtask : t_event

   // every pin of ports six and eight and pins 0-3 of port seven on its alternate source, two source patterns
   task automatic t_alt;
      wr_reg(`MPG_OFS_DIR7, 8'h00);
      wr_reg(`MPG_OFS_DIR8, 8'h00);
      wr_reg(`MPG_OFS_FSEL7, 8'hff);
      wr_reg(`MPG_OFS_FSEL8, 8'hff);
      wr_reg(`MPG_OFS_FSEL6, 8'hff);
      rd_chk(`MPG_OFS_FSEL7, 8'h7f, "port seven select width");
      @(posedge clk);
      alt <= 6'h11;
      settle(3);
      check({1'b0, oe7}, 8'h7f, "port seven oe");
      check(oe8, 8'hff, "port eight oe");
      check({1'b0, out7}, 8'h08, "seven alt a");
      check(out8, 8'h99, "eight alt a");
      check(out6, 8'h11, "six alt a");
      @(posedge clk);
      alt <= 6'h2e;
      settle(3);
      check({1'b0, out7}, 8'h07, "seven alt b");
      check(out8, 8'h66, "eight alt b");
      check(out6, 8'hee, "six alt b");
   endtask : t_alt

   task automatic t_standby;
      logic [7:0] v;
      @(posedge clk);
      sby_n <= 1'b0;
      @(posedge clk);
      sby_n <= 1'b1;
      rd_chk(`MPG_OFS_ENABLE, 8'h00, "standby clears enable");
      settle(1);
      check({1'b0, oe7}, 8'h00, "inactive port oe");
      wr_reg(`MPG_OFS_DIR6, 8'hff);
      settle(6);
      rd_reg(`MPG_OFS_EVT6, v);
      @(posedge clk);
      drv6 <= 8'h5f;
      settle(6);
      rd_chk(`MPG_OFS_EVT6, 8'h00, "inactive port no events");
      rd_chk(`MPG_OFS_DATA6, 8'h5f, "input pin read");
   endtask : t_standby

   // ========================================================================
   // closing and main sequence
   task automatic end_sim;
      $display("checks %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : end_sim

   // the whole run needs well under a thousand cycles
   initial begin
      #40000;
      failures++;
      end_sim();
   end

   initial begin
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      settle(1);
      t_reset();
      t_data();
      t_event();
      t_alt();
      t_standby();
      end_sim();
   end
endmodule : mpg_gpio_tb

`default_nettype wire
